// File: logic/upsc_pkg.sv
// constants for the usb power and suspend control block
package upsc_pkg;
    // register port
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_POWER_CTL = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h08;

    // usb_power_control field positions
    localparam int          BIT_POWER_ON  = 0;
    localparam int          BIT_SUSPEND   = 1;
    localparam int          BIT_NOT_READY = 3;
    localparam int          BIT_GUARD     = 4;
    localparam int          BIT_ACT_PEND  = 7;

    // interrupt status and mask field positions
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_ACTIVITY  = 0;
    localparam int          IRQ_READY     = 1;

    // reset values
    localparam logic [31:0] RST_POWER_CTL = 32'h0000_0000;
    localparam logic [1:0]  RST_IRQ       = 2'h0;

    // clock and shutdown timing
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          SHUTDOWN_NS   = 200;
    localparam int          SHUTDOWN_CYC  =
        (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 4;

    // state of the power-down tracker
    typedef enum logic [2:0] {
        UPSC_OFF_READY = 3'b001,
        UPSC_RUNNING   = 3'b010,
        UPSC_DRAINING  = 3'b100
    } upsc_state_t;
endpackage

// File: logic/upsc_core_if.sv
// signals between register front end and power-down tracker
`timescale 1ns/1ns
`default_nettype none
interface upsc_core_if;
    logic power_on;       // module power-on from the register
    logic activity;       // synchronised bus activity level
    logic activity_edge;  // one-cycle pulse on new activity
    logic not_ready;      // module active or still shutting down

    modport ctrl
    (
        output power_on,
        input  activity,
        input  activity_edge,
        input  not_ready
    );
    modport core
    (
        input  power_on,
        output activity,
        output activity_edge,
        output not_ready
    );
endinterface
`default_nettype wire

// File: logic/upsc_tracker.sv
// activity synchroniser and power-down readiness tracker
`timescale 1ns/1ns
`default_nettype none
module upsc_tracker
(
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // bus activity pin
    input  wire logic  usb_activity_i,
    // link to the register front end
    upsc_core_if.core  core
);
    logic                          sync1_q;
    logic                          sync2_q;
    logic                          sync3_q;
    upsc_pkg::upsc_state_t         state_q;
    upsc_pkg::upsc_state_t         state_d;
    logic [upsc_pkg::CNT_W-1:0]    cnt_q;
    logic [upsc_pkg::CNT_W-1:0]    cnt_d;
    wire logic                     cnt_zero;

    // two-flop synchroniser; third flop only for the edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= usb_activity_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign core.activity      = sync2_q;
    assign core.activity_edge = sync2_q & ~sync3_q;
    assign cnt_zero           = (cnt_q == '0);

    // analog and pins need time to settle after power-off
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            upsc_pkg::UPSC_OFF_READY:
                if (core.power_on)
                    state_d = upsc_pkg::UPSC_RUNNING;
            upsc_pkg::UPSC_RUNNING:
                if (!core.power_on)
                begin
                    state_d = upsc_pkg::UPSC_DRAINING;
                    cnt_d   = upsc_pkg::CNT_W'(upsc_pkg::SHUTDOWN_CYC);
                end
            upsc_pkg::UPSC_DRAINING:
                if (cnt_zero)
                    state_d = upsc_pkg::UPSC_OFF_READY;
                else
                    cnt_d = cnt_q - 1'b1;
            default:
                state_d = upsc_pkg::UPSC_OFF_READY;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= upsc_pkg::UPSC_OFF_READY;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // busy while on or draining, clear only when off and settled
    assign core.not_ready = (state_q != upsc_pkg::UPSC_OFF_READY); // RULE3
endmodule
`default_nettype wire

// File: logic/upsc_top.sv
// usb power and suspend control: register port, irq, sleep guard
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1: the activity pending flag is set when bus activity is seen but its interrupt is not yet raised, and clears when none is pending.
// RULE2: with the sleep guard set, sleep entry is blocked on bus activity or a pending notification; with it clear the block never stops sleep.
// RULE3: the not-ready flag reads 1 while the module is on or still shutting down, and 0 only when off and ready.
// RULE4: the suspend request gates off the 48 MHz usb clock and puts the transceiver in low power; clear means normal operation.
// RULE5: power-on runs the module; when clear, outputs are inactive, pins are released and analog is shut down.
// RULE6: software ignores other usb status and avoids usb register writes while off and not ready.
// RULE7: unimplemented power control bits 31-8, 6-5 and 2 read as zero.
// RULE8: implemented power control bits reset to zero and writes to the activity pending flag are ignored.
module upsc_top
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // usb bus side
    input  wire logic        usb_activity_i,
    output logic             usb_clk_en_o,
    output logic             xcvr_low_power_o,
    output logic             module_enable_o,
    output logic             pins_owned_o,
    output logic             analog_en_o,
    // sleep controller
    output logic             sleep_block_o,
    // interrupt
    output logic             irq_o
);
    upsc_core_if core_if ();

    logic                          power_on_q;
    logic                          suspend_q;
    logic                          guard_q;
    logic                          act_pend_q;
    logic                          act_pend_d;
    logic                          not_ready_q;
    logic [upsc_pkg::IRQ_W-1:0]    stat_q;
    logic [upsc_pkg::IRQ_W-1:0]    stat_d;
    logic [upsc_pkg::IRQ_W-1:0]    mask_q;
    logic [31:0]                   rdata_q;
    logic [31:0]                   rdata_d;
    logic                          usb_clk_en_q;
    logic                          xcvr_low_q;
    logic                          enable_q;
    logic                          sleep_block_q;

    wire logic                     sel_ctl;
    wire logic                     sel_stat;
    wire logic                     sel_mask;
    wire logic                     wr_ctl;
    wire logic                     wr_mask;
    wire logic                     rd_stat;
    wire logic                     running;
    wire logic                     act_evt;
    wire logic                     ready_evt;
    logic      [upsc_pkg::IRQ_W-1:0] events;
    wire logic [upsc_pkg::IRQ_W-1:0] stat_clr;
    wire logic                     notify_pend;
    logic      [31:0]              ctl_view;

    upsc_tracker u_tracker
    (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .usb_activity_i (usb_activity_i),
        .core           (core_if.core)
    );

    assign core_if.power_on = power_on_q;

    // address decode
    assign sel_ctl  = (addr_i == upsc_pkg::OFS_POWER_CTL);
    assign sel_stat = (addr_i == upsc_pkg::OFS_IRQ_STAT);
    assign sel_mask = (addr_i == upsc_pkg::OFS_IRQ_MASK);
    assign wr_ctl   = wr_i & sel_ctl;
    assign wr_mask  = wr_i & sel_mask;
    assign rd_stat  = rd_i & sel_stat;

    // clock is live only when on and not suspended
    assign running  = power_on_q & ~suspend_q;

    // activity seen while on but suspended cannot raise an
    // interrupt yet, so it waits in the pending flag until resume
    assign act_evt  = running & (core_if.activity_edge | act_pend_q);
    always_comb
    begin
        act_pend_d = act_pend_q;
        if (!power_on_q)
            act_pend_d = 1'b0;
        else if (suspend_q && core_if.activity_edge)
            act_pend_d = 1'b1; // RULE1
        else if (act_evt)
            act_pend_d = 1'b0; // RULE1
    end

    // module became ready to be enabled again
    assign ready_evt = not_ready_q & ~core_if.not_ready;

    // sticky status: read clears, a new event in that cycle wins
    always_comb
    begin
        events = '0;
        events[upsc_pkg::IRQ_ACTIVITY] = act_evt;
        events[upsc_pkg::IRQ_READY]    = ready_evt;
    end
    assign stat_clr = rd_stat ? '1 : '0;
    assign stat_d   = (stat_q & ~stat_clr) | events;

    assign notify_pend = |(stat_q & mask_q);

    // register view, unimplemented bits tied low
    always_comb
    begin
        ctl_view = '0; // RULE7
        ctl_view[upsc_pkg::BIT_POWER_ON]  = power_on_q;
        ctl_view[upsc_pkg::BIT_SUSPEND]   = suspend_q;
        // tracker lags power-on by two edges, so on counts as busy
        ctl_view[upsc_pkg::BIT_NOT_READY] = power_on_q | not_ready_q; // RULE3
        ctl_view[upsc_pkg::BIT_GUARD]     = guard_q;
        ctl_view[upsc_pkg::BIT_ACT_PEND]  = act_pend_q; // RULE1
    end

    // read mux; unmapped addresses read as zero
    always_comb
    begin
        rdata_d = '0;
        if (rd_i && sel_ctl)
            rdata_d = ctl_view;
        else if (rd_stat)
            rdata_d = 32'(stat_q);
        else if (rd_i && sel_mask)
            rdata_d = 32'(mask_q);
    end

    // software-written controls; read-only bits never take writes
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            power_on_q <= upsc_pkg::RST_POWER_CTL[upsc_pkg::BIT_POWER_ON];
            suspend_q  <= upsc_pkg::RST_POWER_CTL[upsc_pkg::BIT_SUSPEND];
            guard_q    <= upsc_pkg::RST_POWER_CTL[upsc_pkg::BIT_GUARD];
            mask_q     <= upsc_pkg::RST_IRQ;
        end
        else
        begin
            if (wr_ctl)
            begin
                power_on_q <= wdata_i[upsc_pkg::BIT_POWER_ON]; // RULE5
                suspend_q  <= wdata_i[upsc_pkg::BIT_SUSPEND]; // RULE4
                guard_q    <= wdata_i[upsc_pkg::BIT_GUARD]; // RULE2
            end
            if (wr_mask)
                mask_q <= wdata_i[upsc_pkg::IRQ_W-1:0];
        end
    end

    // hardware-owned state, all cleared by reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            act_pend_q  <= upsc_pkg::RST_POWER_CTL[upsc_pkg::BIT_ACT_PEND]; // RULE8
            not_ready_q <= upsc_pkg::RST_POWER_CTL[upsc_pkg::BIT_NOT_READY]; // RULE8
            stat_q      <= upsc_pkg::RST_IRQ;
            rdata_q     <= '0;
        end
        else
        begin
            act_pend_q  <= act_pend_d;
            not_ready_q <= core_if.not_ready;
            stat_q      <= stat_d;
            rdata_q     <= rdata_d;
        end
    end

    // registered pin-side controls, one cycle after the write
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            usb_clk_en_q  <= 1'b0;
            xcvr_low_q    <= 1'b1;
            enable_q      <= 1'b0;
            sleep_block_q <= 1'b0;
        end
        else
        begin
            usb_clk_en_q  <= running; // RULE4
            xcvr_low_q    <= ~running; // RULE4
            enable_q      <= power_on_q; // RULE5
            sleep_block_q <= guard_q &
                (core_if.activity | act_pend_q | notify_pend); // RULE2
        end
    end

    assign rdata_o          = rdata_q;
    assign usb_clk_en_o     = usb_clk_en_q;
    assign xcvr_low_power_o = xcvr_low_q;
    assign module_enable_o  = enable_q; // RULE5
    assign pins_owned_o     = enable_q;
    assign analog_en_o      = enable_q;
    assign sleep_block_o    = sleep_block_q;
    assign irq_o            = notify_pend;
endmodule
`default_nettype wire

// File: tb/upsc_chk.sv
// port assertions for the usb power and suspend control block
`timescale 1ns/1ns
`default_nettype none
module upsc_chk
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // usb, sleep and interrupt side
    input wire logic        usb_clk_en_o,
    input wire logic        xcvr_low_power_o,
    input wire logic        module_enable_o,
    input wire logic        pins_owned_o,
    input wire logic        analog_en_o,
    input wire logic        sleep_block_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic ctl_a;
    logic ctl_w;
    logic guard_q;
    logic pwr_q;
    // shadow of writable fields, since they never reach a port
    assign ctl_a = addr_i == upsc_pkg::OFS_POWER_CTL;
    assign ctl_w = wr_i && ctl_a;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            guard_q <= 1'b0;
            pwr_q   <= 1'b0;
        end
        else if (ctl_w)
        begin
            guard_q <= wdata_i[upsc_pkg::BIT_GUARD];
            pwr_q   <= wdata_i[upsc_pkg::BIT_POWER_ON];
        end
    AST_RSVD_ZERO: assert property (rd_i && ctl_a |=>
        rdata_o[31:8] == 24'h0 && rdata_o[6:5] == 2'h0 && !rdata_o[2])
        else $error("unused control bits read nonzero");
    AST_OFF_PEND: assert property (
        rd_i && ctl_a && !pwr_q && !$past(pwr_q) |=> !rdata_o[7])
        else $error("pending flag set while off");
    AST_BUSY_ON: assert property (
        rd_i && ctl_a && pwr_q |=> rdata_o[3])
        else $error("busy flag low while on");
    AST_SAME_EN: assert property (
        module_enable_o == pins_owned_o && module_enable_o == analog_en_o)
        else $error("enable outputs disagree");
    AST_ON_RUNS: assert property (
        ctl_w && wdata_i[0] |-> ##[1:2] module_enable_o)
        else $error("module not enabled after power on");
    AST_SUSP_GATE: assert property (
        ctl_w && wdata_i[1] |-> ##[2:3] !usb_clk_en_o && xcvr_low_power_o)
        else $error("clock not gated in suspend");
    AST_RUN_CLK: assert property (
        ctl_w && wdata_i[1:0] == 2'h1 |-> ##[2:3] usb_clk_en_o)
        else $error("clock not running");
    AST_CLK_ON: assert property (
        usb_clk_en_o |-> module_enable_o && !xcvr_low_power_o)
        else $error("clock runs while off or low power");
    AST_GUARD_OFF: assert property (
        !$past(guard_q) |-> !sleep_block_o)
        else $error("sleep blocked without guard");
    AST_GUARD_IRQ: assert property (
        $past(guard_q) && $past(irq_o) |-> sleep_block_o)
        else $error("sleep not blocked on notification");
    // main scenarios
    cover property (ctl_w && wdata_i[1]);
    cover property (sleep_block_o);
    cover property (irq_o ##1 !irq_o);
endmodule
`default_nettype wire

// File: tb/upsc_act_model.sv
// usb bus activity source, asynchronous to the bench clock
`timescale 1ns/1ns
`default_nettype none
module upsc_act_model
(
    // request from the bench
    input  wire logic clk_i,
    input  wire logic go_i,
    // bus activity level
    output logic      usb_activity_o
);
    // burst starts off the edge so the synchroniser sees a real async pin
    initial
    begin
        usb_activity_o = 1'b0;
        forever
        begin
            @(posedge clk_i iff go_i);
            #($urandom_range(37, 3));
            usb_activity_o = 1'b1;
            repeat ($urandom_range(4, 2)) @(posedge clk_i);
            #7 usb_activity_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_usb_power_suspend_control.sv
// self-checking bench for the usb power and suspend control block
`timescale 1ns/1ns
`default_nettype none
module test_usb_power_suspend_control;
    logic        clk_i;
    logic        rst_i;
    logic        wr_i;
    logic        rd_i;
    logic        go;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic [31:0] rdata_o;
    logic [31:0] q;
    logic [31:0] wval;
    logic        act;
    logic        clk_en;
    logic        lowp;
    logic        men;
    logic        pins;
    logic        ana;
    logic        sblk;
    logic        irq_o;
    int          miscompares;
    int          tests_run;
    int          i;
    upsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .usb_activity_i(act), .usb_clk_en_o(clk_en),
        .xcvr_low_power_o(lowp), .module_enable_o(men),
        .pins_owned_o(pins), .analog_en_o(ana), .sleep_block_o(sblk),
        .irq_o(irq_o));
    upsc_act_model bus (.clk_i(clk_i), .go_i(go), .usb_activity_o(act));
    // 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        q = rdata_o;
    endtask
    // bounded wait on irq_o; a hang ends the run
    task automatic wirq(input logic v);
        int k;
        for (k = 0; k < 60 && irq_o !== v; k++)
            @(negedge clk_i);
        chk(32'(irq_o), 32'(v));
        if (k == 60)
            final_report();
    endtask
    task automatic burst;
        @(posedge clk_i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    function automatic logic [31:0] ctl_exp(input logic [31:0] d,
        input logic busy, input logic pend);
        return {24'h0, pend, 2'h0, d[4], busy, 1'b0, d[1:0]};
    endfunction
    initial
    begin
        rst_i       = 1'b1;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        go          = 1'b0;
        addr_i      = 8'h00;
        wdata_i     = 32'h0;
        miscompares = 0;
        tests_run   = 0;
        q = $urandom(32'h06c6);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, then an unmapped word
        for (i = 0; i < 4; i++)
        begin
            rd(8'(4 * i));
            chk(q, 32'h0);
        end
        // random mask traffic; status and unmapped writes are dropped
        for (i = 0; i < 8; i++)
        begin
            wval = $urandom;
            wr(8'h08, wval);
            wr(8'h04, 32'hffff_ffff);
            wr(8'h0c, $urandom);
            rd(8'h08);
            chk(q, {30'h0, wval[1:0]});
            rd(8'h04);
            chk(q, 32'h0);
        end
        wr(8'h08, 32'h3);
        // all ones: on, suspended, guarded; read-only bits refuse
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00);
        chk(q, ctl_exp(32'hffff_ffff, 1'b1, 1'b0));
        chk(32'({men, pins, ana, clk_en, lowp}), 32'h1d);
        // activity while on but suspended stays pending
        burst();
        rd(8'h00);
        chk(q, ctl_exp(32'h13, 1'b1, 1'b1));
        chk(32'(sblk), 32'h1);
        // resume turns the pending activity into an interrupt
        wr(8'h00, 32'h11);
        wirq(1'b1);
        rd(8'h00);
        chk(q, ctl_exp(32'h11, 1'b1, 1'b0));
        chk(32'({clk_en, lowp, sblk}), 32'h5);
        rd(8'h04);
        chk(q, 32'h1);
        wirq(1'b0);
        // without the guard, activity never blocks sleep
        wr(8'h00, 32'h1);
        burst();
        wirq(1'b1);
        repeat (2) @(negedge clk_i);
        chk(32'(sblk), 32'h0);
        rd(8'h04);
        chk(q, 32'h1);
        wirq(1'b0);
        // power down: busy until the module has settled
        wr(8'h00, 32'h0);
        rd(8'h00);
        chk(q, 32'h8);
        chk(32'({men, pins, ana}), 32'h0);
        for (i = 0; i < 20 && q[3] !== 1'b0; i++)
            rd(8'h00);
        chk(q, 32'h0);
        rd(8'h04);
        chk(q, 32'h2);
        // activity while off is ignored
        burst();
        rd(8'h04);
        chk(q, 32'h0);
        final_report();
    end
endmodule
bind upsc_top upsc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .usb_clk_en_o(usb_clk_en_o),
    .xcvr_low_power_o(xcvr_low_power_o),
    .module_enable_o(module_enable_o), .pins_owned_o(pins_owned_o),
    .analog_en_o(analog_en_o), .sleep_block_o(sleep_block_o),
    .irq_o(irq_o));
`default_nettype wire
